// File: hw/pdo_sched_pkg.sv
package pdo_sched_pkg;

	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	localparam logic [15:0] SYNC_PERIOD_MS_RST = 16'h0032;
	localparam logic [7:0] TYPE_ACYCLIC = 8'h00;
	localparam logic [7:0] TYPE_CYCLIC_MAX = 8'hF0;
	localparam logic [7:0] TYPE_EVENT_A = 8'hFE;
	localparam logic [7:0] TYPE_EVENT_B = 8'hFF;
	localparam logic [7:0] RX_TYPE_RST = 8'hFF;
	localparam logic [7:0] TX_TYPE_RST = 8'h01;
	localparam logic [15:0] EVT_MS_RST = 16'h0000;
	localparam logic [15:0] INH_MS_RST = 16'h0000;

	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] REG_SYNC_PERIOD = 4'h0;
	localparam logic [3:0] REG_RX1_TYPE = 4'h1;
	localparam logic [3:0] REG_RX2_TYPE = 4'h2;
	localparam logic [3:0] REG_TX1_TYPE = 4'h3;
	localparam logic [3:0] REG_TX1_EVENT = 4'h4;
	localparam logic [3:0] REG_TX1_INHIBIT = 4'h5;
	localparam logic [3:0] REG_SPEED_CMD = 4'h6;
	localparam logic [3:0] REG_INPUT_SRC = 4'h7;
	localparam logic [3:0] REG_DIGITAL_IN = 4'h8;
	localparam logic [3:0] REG_STATUS_MON = 4'h9;
	localparam logic [3:0] REG_STATE = 4'hA;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [31:0] speed_cmd;
		logic [15:0] input_src;
		logic [15:0] digital_in;
	} rx_image_t;

	function automatic logic is_cyclic(input logic [7:0] t);
		return (t != TYPE_ACYCLIC) && (t <= TYPE_CYCLIC_MAX);
	endfunction : is_cyclic

	function automatic logic is_event(input logic [7:0] t);
		return (t == TYPE_EVENT_A) || (t == TYPE_EVENT_B);
	endfunction : is_event

endpackage : pdo_sched_pkg

// File: hw/pdo_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module pdo_trigger (
	input wire logic i_clk_sys, // System clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_tick, // 1 ms enable
	input wire logic i_sync, // SYNC pulse
	input wire logic i_is_tx, // Channel runs slave to master
	input wire logic [7:0] i_type, // Transmission type
	input wire logic i_change, // Mapped data changed, pulse
	input wire logic [15:0] i_evt_ms, // Event timer, ms
	input wire logic [15:0] i_inh_ms, // Inhibit time, ms
	output logic o_send // Transmit this PDO, pulse
);
	import pdo_sched_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic chg;
		logic due;
		logic [15:0] evt;
		logic [15:0] inh;
		logic send;
	} trig_state_t;

	trig_state_t st_q, st_d;
	logic go;
	logic evt_hit;

	always_comb begin
		st_d = st_q;
		st_d.send = 1'b0;
		go = 1'b0;
		evt_hit = 1'b0;
		if (i_tick && st_q.inh != 16'h0000) begin
			st_d.inh = st_q.inh - 16'h0001;
		end
		if (is_cyclic(i_type)) begin
			if (i_sync) begin
				if (st_q.cnt + 8'h01 >= i_type) begin
					go = 1'b1;
					st_d.cnt = 8'h00;
				end else begin
					st_d.cnt = st_q.cnt + 8'h01;
				end
			end
		end else if (i_type == TYPE_ACYCLIC) begin
			// receive side sends on change, transmit waits SYNC
			go = st_q.chg && (!i_is_tx || i_sync);
		end else if (is_event(i_type)) begin
			if (i_evt_ms == 16'h0000 && i_inh_ms == 16'h0000) begin
				go = st_q.chg;
			end else begin
				if (i_tick && i_evt_ms != 16'h0000) begin
					if (st_q.evt + 16'h0001 >= i_evt_ms) begin
						evt_hit = 1'b1;
						st_d.evt = 16'h0000;
					end else begin
						st_d.evt = st_q.evt + 16'h0001;
					end
				end
				go = (st_q.due || (st_q.chg && i_evt_ms == 16'h0000))
					&& st_q.inh == 16'h0000;
			end
		end
		if (go) begin
			st_d.send = 1'b1;
			st_d.chg = 1'b0;
			st_d.due = 1'b0;
			st_d.inh = i_inh_ms;
		end
		// Timer expiry in the send cycle is kept
		if (evt_hit) begin
			st_d.due = 1'b1;
		end
		if (!is_cyclic(i_type)) begin
			st_d.cnt = 8'h00;
		end
		// Change arriving with the send is kept
		if (i_change) begin
			st_d.chg = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_send = st_q.send;

	inhibit_gap_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st_q.send && st_q.inh != 16'h0000) |=> !st_q.send)
		else $error("resend inside inhibit window");

	sync_count_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(is_cyclic(i_type) && $stable(i_type) && $past(i_sync))
		|-> st_q.cnt < i_type)
		else $error("sync counter passed configured N");

	// type 1 sends on every SYNC
	cyclic_one_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_sync && i_type == 8'h01) |=> st_q.send)
		else $error("type 1 missed a SYNC");

	// event type change sends next cycle
	event_change_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st_q.chg && is_event(i_type) && i_evt_ms == 16'h0000
		&& i_inh_ms == 16'h0000) |=> st_q.send)
		else $error("event type change not sent");

	cover_event_timer_c: cover property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) st_q.due && st_q.inh == 16'h0000);

endmodule : pdo_trigger
`default_nettype wire

// File: hw/pdo_transmission_scheduler.sv
// Notes on behaviour
// - Receive PDOs carry master data to the slave and transmit PDOs carry slave data back to the master.
// - The master emits SYNC at a configurable period that defaults to 50 ms.
// - Asynchronous PDOs go out when mapped data changes, with no SYNC wait, except transmit ones with an event timer set, which send on timer expiry only.
// - Receive type 0 sends at once on change, never otherwise, and the slave applies it at the next SYNC.
// - Transmit type 0 sends at SYNC only if data changed, and the master takes it as valid on arrival.
// - Receive type N (1 to 240) sends every N SYNCs regardless of change and is applied at the next SYNC.
// - Transmit type N (1 to 240) sends every N SYNCs regardless of change and is valid on arrival.
// - Receive types 254 and 255 send at once on change, never otherwise, and apply on reception.
// - Transmit types 254 and 255 send once per event interval when the event timer is set, otherwise on change, and then hold off for the inhibit time.
// - With both timers zero, transmit types 254 and 255 send on every change and are valid at once.
// - After reset the first receive PDO carries the speed command and the second the input source and digital inputs, both type 255.
// - After reset the first transmit PDO carries the status monitor with type 1, sent on every SYNC.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pdo_transmission_scheduler #(
	parameter int unsigned P_TICK_CYCLES = pdo_sched_pkg::TICK_CYCLES
) (
	input wire logic i_clk_sys, // System clock, 25 MHz
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic [pdo_sched_pkg::ADDR_W-1:0] i_addr, // Register index
	input wire logic [31:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [31:0] i_status_mon, // Slave status value
	output logic [31:0] o_rdata, // Read data, cycle after strobe
	output logic o_sync, // SYNC emitted, pulse
	output logic [1:0] o_rx_send, // Receive PDO sent, pulse
	output logic o_tx_send, // Transmit PDO sent, pulse
	output pdo_sched_pkg::rx_image_t o_rx_applied, // Slave applied data
	output logic [31:0] o_status_rcv, // Master received status
	output logic o_status_valid // Received status valid
);
	import pdo_sched_pkg::*;

	typedef struct packed {
		logic [15:0] sync_ms;
		logic [1:0][7:0] rx_type;
		logic [7:0] tx_type;
		logic [15:0] evt_ms;
		logic [15:0] inh_ms;
		rx_image_t master_img;
		rx_image_t slave_rcv;
		rx_image_t slave_app;
		logic [1:0] rx_pend;
		logic [1:0] rx_chg;
		logic [31:0] status_prev;
		logic tx_chg;
		logic [31:0] status_rcv;
		logic status_valid;
		logic [15:0] tick_cnt;
		logic tick;
		logic [15:0] ms_cnt;
		logic sync;
		logic [15:0] sync_total;
		logic [1:0] rx_send;
		logic tx_send;
		logic [31:0] rdata;
	} top_state_t;

	top_state_t st_q, st_d;
	logic [2:0] trig_send;
	logic [2:0] trig_change;
	logic [2:0][7:0] trig_type;
	logic [2:0] trig_is_tx;
	logic [15:0] tick_last;
	rx_image_t wr_img;

	assign tick_last = 16'(P_TICK_CYCLES - 1);
	assign trig_type = {st_q.tx_type, st_q.rx_type[1], st_q.rx_type[0]};
	assign trig_change = {st_q.tx_chg, st_q.rx_chg};
	assign trig_is_tx = 3'b100;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			pdo_trigger u_trig (
				.i_clk_sys(i_clk_sys),
				.i_sys_rst(i_sys_rst),
				.i_tick(st_q.tick),
				.i_sync(st_q.sync),
				.i_is_tx(trig_is_tx[gi]),
				.i_type(trig_type[gi]),
				.i_change(trig_change[gi]),
				.i_evt_ms(trig_is_tx[gi] ? st_q.evt_ms : 16'h0000),
				.i_inh_ms(trig_is_tx[gi] ? st_q.inh_ms : 16'h0000),
				.o_send(trig_send[gi])
			);
		end
	endgenerate

	always_comb begin
		st_d = st_q;
		wr_img = st_q.master_img;
		st_d.tick = 1'b0;
		st_d.sync = 1'b0;
		st_d.rx_chg = 2'b00;
		st_d.rdata = 32'h0000_0000;
		// 1 ms enable from the system clock
		if (st_q.tick_cnt >= tick_last) begin
			st_d.tick_cnt = 16'h0000;
			st_d.tick = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
		end
		if (st_q.tick && st_q.sync_ms != 16'h0000) begin
			if (st_q.ms_cnt + 16'h0001 >= st_q.sync_ms) begin
				st_d.ms_cnt = 16'h0000;
				st_d.sync = 1'b1;
				st_d.sync_total = st_q.sync_total + 16'h0001;
			end else begin
				st_d.ms_cnt = st_q.ms_cnt + 16'h0001;
			end
		end
		if (i_wr) begin
			case (i_addr)
				REG_SYNC_PERIOD: st_d.sync_ms = i_wdata[15:0];
				REG_RX1_TYPE: st_d.rx_type[0] = i_wdata[7:0];
				REG_RX2_TYPE: st_d.rx_type[1] = i_wdata[7:0];
				REG_TX1_TYPE: st_d.tx_type = i_wdata[7:0];
				REG_TX1_EVENT: st_d.evt_ms = i_wdata[15:0];
				REG_TX1_INHIBIT: st_d.inh_ms = i_wdata[15:0];
				REG_SPEED_CMD: wr_img.speed_cmd = i_wdata;
				REG_INPUT_SRC: wr_img.input_src = i_wdata[15:0];
				REG_DIGITAL_IN: wr_img.digital_in = i_wdata[15:0];
				default: ;
			endcase
		end
		// a changed value raises the channel's change event
		st_d.rx_chg[0] = wr_img.speed_cmd != st_q.master_img.speed_cmd;
		st_d.rx_chg[1] = {wr_img.input_src, wr_img.digital_in}
			!= {st_q.master_img.input_src, st_q.master_img.digital_in};
		st_d.master_img = wr_img;
		st_d.status_prev = i_status_mon;
		st_d.tx_chg = i_status_mon != st_q.status_prev;
		if (i_rd) begin
			case (i_addr)
				REG_SYNC_PERIOD: st_d.rdata = {16'h0000, st_q.sync_ms};
				REG_RX1_TYPE: st_d.rdata = {24'h000000, st_q.rx_type[0]};
				REG_RX2_TYPE: st_d.rdata = {24'h000000, st_q.rx_type[1]};
				REG_TX1_TYPE: st_d.rdata = {24'h000000, st_q.tx_type};
				REG_TX1_EVENT: st_d.rdata = {16'h0000, st_q.evt_ms};
				REG_TX1_INHIBIT: st_d.rdata = {16'h0000, st_q.inh_ms};
				REG_SPEED_CMD: st_d.rdata = st_q.master_img.speed_cmd;
				REG_INPUT_SRC: st_d.rdata = {16'h0000, st_q.master_img.input_src};
				REG_DIGITAL_IN: st_d.rdata = {16'h0000,
					st_q.master_img.digital_in};
				REG_STATUS_MON: st_d.rdata = st_q.status_rcv;
				REG_STATE: st_d.rdata = {st_q.sync_total, 13'h0000,
					st_q.status_valid, st_q.rx_pend};
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
		if (st_q.sync) begin
			if (st_q.rx_pend[0]) begin
				st_d.slave_app.speed_cmd = st_q.slave_rcv.speed_cmd;
			end
			if (st_q.rx_pend[1]) begin
				st_d.slave_app.input_src = st_q.slave_rcv.input_src;
				st_d.slave_app.digital_in = st_q.slave_rcv.digital_in;
			end
			st_d.rx_pend = 2'b00;
		end
		// receive PDOs carry master image to slave
		st_d.rx_send = trig_send[1:0];
		if (trig_send[0]) begin
			st_d.slave_rcv.speed_cmd = st_q.master_img.speed_cmd;
			if (is_event(st_q.rx_type[0])) begin
				st_d.slave_app.speed_cmd = st_q.master_img.speed_cmd;
			end else begin
				st_d.rx_pend[0] = 1'b1;
			end
		end
		if (trig_send[1]) begin
			st_d.slave_rcv.input_src = st_q.master_img.input_src;
			st_d.slave_rcv.digital_in = st_q.master_img.digital_in;
			if (is_event(st_q.rx_type[1])) begin
				st_d.slave_app.input_src = st_q.master_img.input_src;
				st_d.slave_app.digital_in = st_q.master_img.digital_in;
			end else begin
				st_d.rx_pend[1] = 1'b1;
			end
		end
		// master takes transmit data as valid at once
		st_d.tx_send = trig_send[2];
		if (trig_send[2]) begin
			st_d.status_rcv = i_status_mon;
			st_d.status_valid = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
			st_q.sync_ms <= SYNC_PERIOD_MS_RST;
			st_q.rx_type <= {RX_TYPE_RST, RX_TYPE_RST};
			st_q.tx_type <= TX_TYPE_RST;
			st_q.evt_ms <= EVT_MS_RST;
			st_q.inh_ms <= INH_MS_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_sync = st_q.sync;
	assign o_rx_send = st_q.rx_send;
	assign o_tx_send = st_q.tx_send;
	assign o_rx_applied = st_q.slave_app;
	assign o_status_rcv = st_q.status_rcv;
	assign o_status_valid = st_q.status_valid;

	// SYNC only on the ms enable
	sync_on_tick_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		st_q.sync |-> $past(st_q.tick) && st_q.sync_ms != 16'h0000)
		else $error("SYNC outside its period");

	rx_defer_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(st_q.rx_pend[0] && !st_q.sync && !trig_send[0])
		|=> $stable(st_q.slave_app.speed_cmd))
		else $error("deferred speed applied before SYNC");

	rx_apply_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(st_q.sync && st_q.rx_pend[0] && !trig_send[0])
		|=> st_q.slave_app.speed_cmd == $past(st_q.slave_rcv.speed_cmd))
		else $error("pending speed not applied on SYNC");

	rx_direct_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(trig_send[1] && is_event(st_q.rx_type[1]))
		|=> o_rx_send[1] && st_q.slave_app.input_src
		== $past(st_q.master_img.input_src))
		else $error("event receive data not applied");

	tx_valid_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		trig_send[2] |=> o_tx_send && o_status_valid
		&& o_status_rcv == $past(i_status_mon))
		else $error("transmit data not taken at once");

	// type 1 transmit follows each SYNC
	tx_every_sync_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(st_q.sync && st_q.tx_type == 8'h01) |-> ##2 o_tx_send)
		else $error("type 1 transmit PDO missed a SYNC");

	rx_change_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(i_wr && i_addr == REG_SPEED_CMD
		&& i_wdata != st_q.master_img.speed_cmd) |=> st_q.rx_chg[0])
		else $error("speed change not flagged");

	// Types that the trigger acts on; 241 to 253 stay silent
	function automatic logic type_live(input logic [7:0] t);
		return is_cyclic(t) || is_event(t) || (t == TYPE_ACYCLIC);
	endfunction : type_live

	rx1_refused_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		trig_send[0] |-> type_live($past(st_q.rx_type[0])))
		else $error("receive PDO 1 sent under a refused type");

	rx2_refused_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		trig_send[1] |-> type_live($past(st_q.rx_type[1])))
		else $error("receive PDO 2 sent under a refused type");

	tx_refused_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		trig_send[2] |-> type_live($past(st_q.tx_type)))
		else $error("transmit PDO sent under a refused type");

	// type 0 transmit only follows a SYNC
	tx_zero_sync_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(trig_send[2] && $past(st_q.tx_type) == TYPE_ACYCLIC)
		|-> $past(st_q.sync))
		else $error("type 0 transmit without SYNC");

	tx_change_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(i_status_mon != st_q.status_prev) |=> st_q.tx_chg)
		else $error("status change not flagged");

	// received status moves only on a send
	tx_status_hold_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		!trig_send[2] |=> $stable(o_status_rcv))
		else $error("received status moved without a send");

	status_sticky_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		$past(o_status_valid) |-> o_status_valid)
		else $error("status valid flag dropped");

	// second receive PDO waits for SYNC
	rx2_defer_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(st_q.rx_pend[1] && !st_q.sync && !trig_send[1])
		|=> $stable(st_q.slave_app.input_src)
		&& $stable(st_q.slave_app.digital_in))
		else $error("deferred inputs applied before SYNC");

	// second receive PDO applied on SYNC
	rx2_apply_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(st_q.sync && st_q.rx_pend[1] && !trig_send[1])
		|=> st_q.slave_app.digital_in
		== $past(st_q.slave_rcv.digital_in))
		else $error("pending inputs not applied on SYNC");

	// first receive PDO applied on reception
	rx1_direct_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(trig_send[0] && is_event(st_q.rx_type[0]))
		|=> o_rx_send[0] && o_rx_applied.speed_cmd
		== $past(st_q.master_img.speed_cmd))
		else $error("event speed data not applied");

	cover_sync_c: cover property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) o_sync ##[1:3] o_tx_send);
	cover_rx_send_c: cover property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) o_rx_send[0]);
	cover_rx_pend_c: cover property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) st_q.rx_pend[1] && st_q.sync);
	cover_tx_zero_c: cover property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) o_tx_send && st_q.tx_type == TYPE_ACYCLIC);

endmodule : pdo_transmission_scheduler
`default_nettype wire

// File: testbench/servo_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module servo_slave_model (
	input wire logic i_clk_sys, // System clock
	input wire logic i_load, // Take a new status value
	input wire logic [31:0] i_value, // Status value to present
	input wire logic [1:0] i_rx_send, // Receive PDO frames on the bus
	output logic [31:0] o_status_mon, // Status monitor value
	output logic [7:0] o_rx_cnt // Receive PDO frames taken
);
	logic [31:0] status_q = 32'h0000_0000;
	logic [7:0] cnt_q = 8'h00;
	always @(posedge i_clk_sys) begin
		if (i_load) begin
			status_q <= i_value;
		end
	end
	// frames from master; unknown before reset counts as none
	always @(posedge i_clk_sys) begin
		cnt_q <= cnt_q + 8'(i_rx_send[0] === 1'b1)
			+ 8'(i_rx_send[1] === 1'b1);
	end
	assign o_status_mon = status_q;
	assign o_rx_cnt = cnt_q;
endmodule : servo_slave_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pdo_sched_pkg::*;
	localparam int TCK = 10;
	localparam int SYNC_CLK = 50 * TCK;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic ld = 1'b0;
	logic [31:0] ld_val = '0;
	logic [31:0] status_mon, rdata, status_rcv;
	logic sync_p, tx_send, status_valid;
	logic [1:0] rx_send;
	rx_image_t applied;
	logic [7:0] rx_cnt;
	int err_total = 0;
	int check_count = 0;

	always #20 i_clk_sys = ~i_clk_sys;

	pdo_transmission_scheduler #(.P_TICK_CYCLES(TCK)) DUT (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_status_mon(status_mon), .o_rdata(rdata), .o_sync(sync_p),
		.o_rx_send(rx_send), .o_tx_send(tx_send),
		.o_rx_applied(applied), .o_status_rcv(status_rcv),
		.o_status_valid(status_valid)
	);

	servo_slave_model u_slave (
		.i_clk_sys(i_clk_sys), .i_load(ld), .i_value(ld_val),
		.i_rx_send(rx_send), .o_status_mon(status_mon), .o_rx_cnt(rx_cnt)
	);

	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	// Slave presents a new status value one edge after the request
	task automatic chg(input logic [31:0] v);
		@(posedge i_clk_sys);
		ld <= 1'b1;
		ld_val <= v;
		@(posedge i_clk_sys);
		ld <= 1'b0;
	endtask : chg

	// Edges until the chosen pulse shows; lim + 1 when it never does
	task automatic wait_ev(input int sel, input int lim, output int n);
		logic hit;
		for (n = 1; n <= lim; n++) begin
			@(posedge i_clk_sys);
			#1;
			case (sel)
				0: hit = rx_send[0];
				1: hit = rx_send[1];
				2: hit = tx_send;
				default: hit = sync_p;
			endcase
			if (hit === 1'b1) break;
		end
	endtask : wait_ev

	task automatic t_defaults;
		logic [31:0] d;
		rd(REG_SYNC_PERIOD, d);
		check("sync_period", 64'(d), 64'(SYNC_PERIOD_MS_RST));
		rd(REG_RX1_TYPE, d);
		check("rx1_type", 64'(d), 64'(RX_TYPE_RST));
		rd(REG_RX2_TYPE, d);
		check("rx2_type", 64'(d), 64'(RX_TYPE_RST));
		rd(REG_TX1_TYPE, d);
		check("tx1_type", 64'(d), 64'(TX_TYPE_RST));
		rd(4'hB, d);
		check("unmapped", 64'(d), 64'h0);
	endtask : t_defaults

	task automatic t_cyclic;
		int n;
		wr(REG_RX2_TYPE, 32'h0000_0001);
		wait_ev(3, SYNC_CLK + 20, n);
		repeat (3) begin
			wait_ev(2, 4, n);
			check("tx_lag", 64'(n), 64'h2);
			check("rx2_cyc", 64'(rx_send[1]), 64'h1);
			check("status_rcv", 64'(status_rcv), 64'h5A5A_0001);
			check("status_valid", 64'(status_valid), 64'h1);
			wait_ev(3, SYNC_CLK, n);
			check("sync_gap", 64'(n), 64'(SYNC_CLK - 2));
		end
		wr(REG_RX2_TYPE, 32'h0000_00FF);
	endtask : t_cyclic

	task automatic t_rx_event;
		int n;
		logic [7:0] c0;
		// Let a frame still in flight from the last scenario be counted
		repeat (2) @(posedge i_clk_sys);
		c0 = rx_cnt;
		wr(REG_SPEED_CMD, 32'h0000_0100);
		wait_ev(0, 4, n);
		check("rx1_lag", 64'(n), 64'h3);
		check("speed", 64'(applied.speed_cmd), 64'h100);
		wr(REG_INPUT_SRC, 32'h0000_000F);
		wait_ev(1, 4, n);
		check("rx2_lag", 64'(n), 64'h3);
		wr(REG_DIGITAL_IN, 32'h0000_0005);
		wait_ev(1, 4, n);
		check("input_src", 64'(applied.input_src), 64'hF);
		check("digital_in", 64'(applied.digital_in), 64'h5);
		wr(REG_SPEED_CMD, 32'h0000_0100);
		wait_ev(0, 8, n);
		check("rx1_quiet", 64'(n), 64'h9);
		check("rx_frames", 64'(rx_cnt - c0), 64'h3);
	endtask : t_rx_event

	task automatic t_rx_zero;
		int n;
		wr(REG_RX1_TYPE, 32'h0000_0000);
		wr(REG_SPEED_CMD, 32'h0000_0200);
		wait_ev(0, 4, n);
		check("rx0_lag", 64'(n), 64'h3);
		check("rx0_held", 64'(applied.speed_cmd), 64'h100);
		wait_ev(3, SYNC_CLK, n);
		@(posedge i_clk_sys);
		#1;
		check("rx0_apply", 64'(applied.speed_cmd), 64'h200);
		wr(REG_RX1_TYPE, 32'h0000_00FE);
		wr(REG_SPEED_CMD, 32'h0000_0300);
		wait_ev(0, 4, n);
		check("rx254_lag", 64'(n), 64'h3);
		check("rx254_apply", 64'(applied.speed_cmd), 64'h300);
		wr(REG_RX1_TYPE, 32'h0000_00F5);
		wr(REG_SPEED_CMD, 32'h0000_0400);
		wait_ev(0, 8, n);
		check("rx_refused", 64'(n), 64'h9);
		check("rx_kept", 64'(applied.speed_cmd), 64'h300);
		wr(REG_RX1_TYPE, 32'h0000_00FF);
	endtask : t_rx_zero

	task automatic t_tx_cyc;
		int n;
		int k;
		k = 0;
		wr(REG_TX1_TYPE, 32'h0000_0002);
		repeat (4) begin
			wait_ev(3, SYNC_CLK, n);
			wait_ev(2, 4, n);
			if (n == 2) k++;
		end
		check("tx_every2", 64'(k), 64'h2);
	endtask : t_tx_cyc

	task automatic t_tx_zero;
		int n;
		wr(REG_TX1_TYPE, 32'h0000_0000);
		wait_ev(3, SYNC_CLK + 20, n);
		wait_ev(3, SYNC_CLK + 20, n);
		wait_ev(2, 4, n);
		check("tx0_quiet", 64'(n), 64'h5);
		chg(32'h5A5A_0002);
		wait_ev(3, SYNC_CLK, n);
		wait_ev(2, 4, n);
		check("tx0_lag", 64'(n), 64'h2);
		check("tx0_status", 64'(status_rcv), 64'h5A5A_0002);
	endtask : t_tx_zero

	task automatic t_tx_event;
		int n;
		wr(REG_TX1_TYPE, 32'h0000_00FF);
		chg(32'h5A5A_0003);
		wait_ev(2, 6, n);
		check("evt_lag", 64'(n), 64'h4);
		check("evt_status", 64'(status_rcv), 64'h5A5A_0003);
		wr(REG_TX1_EVENT, 32'h0000_0002);
		wait_ev(2, 40, n);
		wait_ev(2, 40, n);
		check("evt_gap", 64'(n), 64'(2 * TCK));
		wr(REG_TX1_EVENT, 32'h0000_0000);
		wr(REG_TX1_INHIBIT, 32'h0000_0003);
		chg(32'h5A5A_0004);
		wait_ev(2, 80, n);
		chg(32'h5A5A_0005);
		wait_ev(2, 80, n);
		check("inh_hold", 64'((n + 2) > 2 * TCK), 64'h1);
		check("inh_late", 64'(n <= 80), 64'h1);
		check("inh_status", 64'(status_rcv), 64'h5A5A_0005);
	endtask : t_tx_event

	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		t_defaults;
		chg(32'h5A5A_0001);
		t_cyclic;
		t_rx_event;
		t_rx_zero;
		t_tx_cyc;
		t_tx_zero;
		t_tx_event;
		close_out;
	end

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		err_total++;
		close_out;
	end
endmodule : tb
`default_nettype wire
